/* File: verilog/mdio_ctrl.sv */
// Input mapping, merging and excitation control of the motor drive
module mdio_ctrl
	import mdio_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [ND-1:0] din,
	input wire logic [NR-1:0] rin,
	input wire logic clockwise_pulse,
	input wire logic counterclockwise_pulse,
	input wire logic pulse_mode,
	input wire logic motor_stopped,
	input wire logic [NO-1:0] status,
	input wire logic map_wr,
	input wire logic [1:0] map_tbl,
	input wire logic [3:0] map_idx,
	input wire logic [FW-1:0] map_val,
	output logic [NF-1:0] func,
	output logic [NR-1:0] rout,
	output logic cw_step,
	output logic ccw_step,
	output logic excite,
	output logic dyn_brake,
	output logic brake_release,
	output logic ready,
	output logic pulse_accept_ready,
	output logic clear_dev,
	output logic halt_now,
	output logic halt_decel,
	output logic discard_travel,
	output logic in_position,
	output logic [1:0] stop_action_setting
);
	typedef struct packed {
		logic [NR-1:0][FW-1:0] rin_map;
		logic [ND-1:0][FW-1:0] din_map;
		logic [NR-1:0][FW-1:0] rout_map;
		logic [1:0] stop_act;
		mdio_st_t st;
		logic [NF-1:0] func;
		logic [NR-1:0] rout;
		logic [1:0] step;
		logic excite;
		logic dyn_brake;
		logic brake_rel;
		logic ready;
		logic pulse_accept_ready_output;
		logic clr_dev;
		logic halt_now;
		logic halt_decel;
		logic discard;
		logic stop_lat;
		logic inpos;
	} mdio_ctrl_t;

	mdio_ctrl_t s_q, s_d;
	logic [ND-1:0] din_s;
	logic [NR-1:0] rin_s;
	logic [1:0] pls_s;
	logic [NF-1:0] act;
	logic [NO-1:0] ost;
	logic con, fre, clr, cof, imm, gate, newmove;

	// Remote slots arrive as link-decoded levels, never from pins
	mdio_sync #(.W(ND + NR + 2)) u_sync (
		.clk(clk),
		.reset(reset),
		.din({din, rin, counterclockwise_pulse, clockwise_pulse}),
		.dout({din_s, rin_s, pls_s})
	);

	// Pulse terminals bypass the map entirely; nothing else can reach them
	for (genvar f = 0; f < NF; f++) begin : g_fn
		logic rm, ra, dm, da;
		always_comb begin
			rm = 1'b0;
			ra = 1'b0;
			dm = 1'b0;
			da = 1'b0;
			for (int i = 0; i < NR; i++) begin
				if (s_q.rin_map[i] == FW'(f)) begin
					rm = 1'b1;
					ra = ra | rin_s[i];
				end
			end
			for (int i = 0; i < ND; i++) begin
				if (s_q.din_map[i] == FW'(f)) begin
					dm = 1'b1;
					da = da | din_s[i];
				end
			end
		end
		if (f == F_EXC_CMD || f == F_PANEL) begin : g_and
			// Missing assignment must not disable the drive
			assign act[f] = (rm && dm) ? (ra & da) :
				rm ? ra : dm ? da : 1'b1;
		end else begin : g_or
			assign act[f] = ra | da;
		end
	end

	assign con = act[F_EXC_CMD];
	assign fre = act[F_RELEASE];
	assign clr = act[F_DEV_CLR];
	assign cof = act[F_STOP_OFF];
	// Deenergizing stop decelerates only for settings 2 and 3, and never in pulse mode
	assign imm = pulse_mode || !s_q.stop_act[1];

	always_comb begin
		ost = status;
		ost[O_NONE] = 1'b0;
		ost[O_ECHO0] = act[F_OP_SEL0];
		ost[O_ECHO1] = act[F_OP_SEL1];
		ost[O_ECHO2] = act[F_OP_SEL2];
		ost[O_START_ECHO] = act[F_START];
		ost[O_READY] = s_q.ready;
		ost[O_INPOS] = s_q.inpos;
		ost[O_PULSE_ACCEPT_READY_OUTPUT] = s_q.pulse_accept_ready_output;
	end

	always_comb begin
		s_d = s_q;
		s_d.func = act;
		if (map_wr) begin
			case (map_tbl)
				T_RIN: s_d.rin_map[map_idx] = map_val;
				T_DIN: begin
					if (32'(map_idx) < ND) begin
						s_d.din_map[map_idx[2:0]] = map_val;
					end
				end
				T_ROUT: s_d.rout_map[map_idx] = map_val;
				default: s_d.stop_act = map_val[1:0];
			endcase
		end
		for (int i = 0; i < NR; i++) begin
			if (32'(s_q.rout_map[i]) < NO) begin
				s_d.rout[i] = ost[s_q.rout_map[i]];
			end else begin
				s_d.rout[i] = 1'b0;
			end
		end
		// Losing the command dominates every other request
		case (s_q.st)
			ST_OFF: begin
				if (con) begin
					s_d.st = fre ? ST_FREE : ST_ENERGIZE;
				end
			end
			ST_ENERGIZE: begin
				if (!con) begin
					s_d.st = ST_OFF;
				end else if (fre) begin
					s_d.st = ST_FREE;
				end else if (cof) begin
					s_d.st = ST_COFF;
				end else begin
					s_d.st = ST_RUN;
				end
			end
			ST_RUN: begin
				if (!con) begin
					s_d.st = ST_OFF;
				end else if (fre) begin
					s_d.st = ST_FREE;
				end else if (cof) begin
					s_d.st = imm ? ST_COFF : ST_STOPPING;
				end
			end
			ST_STOPPING: begin
				if (!con) begin
					s_d.st = ST_OFF;
				end else if (fre) begin
					s_d.st = ST_FREE;
				end else if (motor_stopped) begin
					// Released mid-ramp: stays excited once at rest
					s_d.st = cof ? ST_COFF : ST_RUN;
				end
			end
			ST_COFF: begin
				if (!con) begin
					s_d.st = ST_OFF;
				end else if (!cof) begin
					s_d.st = fre ? ST_FREE : ST_ENERGIZE;
				end
			end
			ST_FREE: begin
				if (!con) begin
					s_d.st = ST_OFF;
				end else if (!fre) begin
					s_d.st = cof ? ST_COFF : ST_ENERGIZE;
				end
			end
			default: s_d.st = ST_OFF;
		endcase
		s_d.excite = s_d.st == ST_ENERGIZE || s_d.st == ST_RUN ||
			s_d.st == ST_STOPPING;
		s_d.dyn_brake = s_d.st == ST_OFF;
		// Brake stays held during the energizing cycle
		s_d.brake_rel = s_d.st == ST_RUN || s_d.st == ST_STOPPING ||
			((s_d.st == ST_FREE || s_d.st == ST_COFF ||
			s_d.st == ST_OFF) && fre);
		s_d.ready = s_d.st == ST_RUN && !clr && !cof;
		s_d.pulse_accept_ready_output = s_d.ready && !act[F_STOP];
		s_d.clr_dev = clr;
		s_d.halt_now = clr || (cof && imm);
		s_d.halt_decel = s_d.st == ST_STOPPING;
		s_d.discard = !pulse_mode && (clr || s_d.st == ST_COFF);
		gate = s_d.st == ST_RUN && !clr && !cof;
		s_d.step = pls_s & {2{gate}};
		newmove = act[F_START] | act[F_SEQ_START] | act[F_HOME] |
			act[F_FORWARD_POSITION_MOVE_INPUT] | act[F_REVERSE_POSITION_MOVE_INPUT] | (|s_d.step);
		// Set wins so a stop in the same cycle as a start is kept
		if (clr || cof || act[F_STOP]) begin
			s_d.stop_lat = 1'b1;
		end else if (newmove) begin
			s_d.stop_lat = 1'b0;
		end
		s_d.inpos = status[O_INPOS] && !s_d.stop_lat;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
			s_q.rin_map <= RIN_DEF;
			s_q.din_map <= DIN_DEF;
			s_q.rout_map <= ROUT_DEF;
			s_q.stop_act <= STOP_ACT_RST;
			s_q.st <= ST_OFF;
		end else begin
			s_q <= s_d;
		end
	end

	assign func = s_q.func;
	assign rout = s_q.rout;
	assign cw_step = s_q.step[0];
	assign ccw_step = s_q.step[1];
	assign excite = s_q.excite;
	assign dyn_brake = s_q.dyn_brake;
	assign brake_release = s_q.brake_rel;
	assign ready = s_q.ready;
	assign pulse_accept_ready = s_q.pulse_accept_ready_output;
	assign clear_dev = s_q.clr_dev;
	assign halt_now = s_q.halt_now;
	assign halt_decel = s_q.halt_decel;
	assign discard_travel = s_q.discard;
	assign in_position = s_q.inpos;
	assign stop_action_setting = s_q.stop_act;

	property p_release_cut;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_RUN && con && fre) |=>
		(!excite && brake_release && !ready && !pulse_accept_ready);
	endproperty
	a_release_cut: assert property (p_release_cut)
		else $error("release did not cut excitation");
	property p_release_back;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_FREE && con && !fre && !cof) |=>
		(s_q.st == ST_ENERGIZE && !brake_release) ##1
		(s_q.st != ST_RUN || (ready == !($past(clr) || $past(cof))));
	endproperty
	a_release_back: assert property (p_release_back)
		else $error("release off did not re-excite");
	property p_unexc_brake;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_FREE || s_q.st == ST_COFF) |->
		(brake_release == $past(fre) && !excite);
	endproperty
	a_unexc_brake: assert property (p_unexc_brake)
		else $error("unexcited brake not following release");
	property p_cmd_off;
		@(posedge clk) disable iff (reset)
		!con |=> (dyn_brake && !excite && !ready && !pulse_accept_ready);
	endproperty
	a_cmd_off: assert property (p_cmd_off)
		else $error("command off not honoured");
	property p_brake_after;
		@(posedge clk) disable iff (reset)
		$rose(excite) |-> !brake_release;
	endproperty
	a_brake_after: assert property (p_brake_after)
		else $error("brake freed before excitation");
	property p_no_inpos;
		@(posedge clk) disable iff (reset)
		(clr || cof || act[F_STOP]) |=> !in_position;
	endproperty
	a_no_inpos: assert property (p_no_inpos)
		else $error("stop raised in-position");
	property p_dev_clear;
		@(posedge clk) disable iff (reset)
		clr |=> (clear_dev && halt_now && !cw_step && !ccw_step);
	endproperty
	a_dev_clear: assert property (p_dev_clear)
		else $error("deviation clear not applied");
	property p_clr_data;
		@(posedge clk) disable iff (reset)
		(clr && !pulse_mode) |=> discard_travel;
	endproperty
	a_clr_data: assert property (p_clr_data)
		else $error("clear did not discard travel");
	property p_clr_ready;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_RUN && $past(clr) && !clr && con && !fre && !cof)
		|=> (ready && pulse_accept_ready == !$past(act[F_STOP]));
	endproperty
	a_clr_ready: assert property (p_clr_ready)
		else $error("clear release did not raise ready");
	property p_coff_pulse;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_RUN && con && !fre && cof && pulse_mode) |=>
		(s_q.st == ST_COFF && !excite && halt_now && !cw_step);
	endproperty
	a_coff_pulse: assert property (p_coff_pulse)
		else $error("pulse mode deenergizing stop wrong");
	property p_coff_decel;
		@(posedge clk) disable iff (reset)
		(s_q.st == ST_RUN && con && !fre && cof && !imm) |=>
		(halt_decel && excite && !pulse_accept_ready);
	endproperty
	a_coff_decel: assert property (p_coff_decel)
		else $error("decelerating stop wrong");

	property p_stop_rst;
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> stop_action_setting == STOP_ACT_RST;
	endproperty
	a_stop_rst: assert property (p_stop_rst)
		else $error("stop action reset value wrong");

	c_free: cover property (@(posedge clk) disable iff (reset)
		s_q.st == ST_FREE ##1 s_q.st == ST_ENERGIZE ##1 s_q.st == ST_RUN);
	c_decel: cover property (@(posedge clk) disable iff (reset)
		s_q.st == ST_STOPPING ##1 s_q.st == ST_COFF);
	c_clr: cover property (@(posedge clk) disable iff (reset)
		clear_dev ##1 !clear_dev && ready);
endmodule : mdio_ctrl

/* File: verilog/mdio_pkg.sv */
// Constants, function codes and defaults for the motor drive I/O control
package mdio_pkg;
	localparam int FW = 5;
	localparam int NF = 21;
	localparam int NO = 18;
	localparam int NR = 16;
	localparam int ND = 6;
	// Input function codes
	localparam logic [4:0] F_NONE = 5'h00;
	localparam logic [4:0] F_OP_SEL0 = 5'h01;
	localparam logic [4:0] F_OP_SEL1 = 5'h02;
	localparam logic [4:0] F_OP_SEL2 = 5'h03;
	localparam logic [4:0] F_START = 5'h04;
	localparam logic [4:0] F_HOME = 5'h05;
	localparam logic [4:0] F_STOP = 5'h06;
	localparam logic [4:0] F_RELEASE = 5'h07;
	localparam logic [4:0] F_ALARM_CLR = 5'h08;
	localparam logic [4:0] F_DSEL0 = 5'h09;
	localparam logic [4:0] F_DSEL1 = 5'h0A;
	localparam logic [4:0] F_DSEL2 = 5'h0B;
	localparam logic [4:0] F_SEQ_START = 5'h0C;
	localparam logic [4:0] F_FW_JOG = 5'h0D;
	localparam logic [4:0] F_RV_JOG = 5'h0E;
	localparam logic [4:0] F_FORWARD_POSITION_MOVE_INPUT = 5'h0F;
	localparam logic [4:0] F_REVERSE_POSITION_MOVE_INPUT = 5'h10;
	localparam logic [4:0] F_EXC_CMD = 5'h11;
	localparam logic [4:0] F_PANEL = 5'h12;
	localparam logic [4:0] F_DEV_CLR = 5'h13;
	localparam logic [4:0] F_STOP_OFF = 5'h14;
	// Output function codes
	localparam logic [4:0] O_NONE = 5'h00;
	localparam logic [4:0] O_ECHO0 = 5'h01;
	localparam logic [4:0] O_ECHO1 = 5'h02;
	localparam logic [4:0] O_ECHO2 = 5'h03;
	localparam logic [4:0] O_START_ECHO = 5'h04;
	localparam logic [4:0] O_HOME_END = 5'h05;
	localparam logic [4:0] O_READY = 5'h06;
	localparam logic [4:0] O_INFORMATION_FLAG_OUTPUT = 5'h07;
	localparam logic [4:0] O_ALARM = 5'h08;
	localparam logic [4:0] O_BUSY = 5'h09;
	localparam logic [4:0] O_ZONE0 = 5'h0A;
	localparam logic [4:0] O_ZONE1 = 5'h0B;
	localparam logic [4:0] O_ZONE2 = 5'h0C;
	localparam logic [4:0] O_TIMING = 5'h0D;
	localparam logic [4:0] O_MOVE = 5'h0E;
	localparam logic [4:0] O_INPOS = 5'h0F;
	localparam logic [4:0] O_TORQUE = 5'h10;
	localparam logic [4:0] O_PULSE_ACCEPT_READY_OUTPUT = 5'h11;
	// Map write table select
	localparam logic [1:0] T_RIN = 2'h0;
	localparam logic [1:0] T_DIN = 2'h1;
	localparam logic [1:0] T_ROUT = 2'h2;
	localparam logic [1:0] T_STOP_ACT = 2'h3;
	localparam logic [1:0] STOP_ACT_RST = 2'h3;
	localparam logic [NR-1:0][FW-1:0] RIN_DEF = {
		F_REVERSE_POSITION_MOVE_INPUT, F_FORWARD_POSITION_MOVE_INPUT, F_RV_JOG, F_FW_JOG,
		F_SEQ_START, F_DSEL2, F_DSEL1, F_DSEL0,
		F_ALARM_CLR, F_RELEASE, F_STOP, F_HOME,
		F_START, F_OP_SEL2, F_OP_SEL1, F_OP_SEL0};
	localparam logic [NR-1:0][FW-1:0] ROUT_DEF = {
		O_TORQUE, O_INPOS, O_MOVE, O_TIMING,
		O_ZONE2, O_ZONE1, O_ZONE0, O_BUSY,
		O_ALARM, O_INFORMATION_FLAG_OUTPUT, O_READY, O_HOME_END,
		O_START_ECHO, O_ECHO2, O_ECHO1, O_ECHO0};
	localparam logic [ND-1:0][FW-1:0] DIN_DEF = {
		F_NONE, F_NONE, F_ALARM_CLR, F_STOP,
		F_RELEASE, F_HOME};
	typedef enum logic [2:0] {
		ST_OFF = 3'h0,
		ST_ENERGIZE = 3'h1,
		ST_RUN = 3'h3,
		ST_STOPPING = 3'h2,
		ST_COFF = 3'h6,
		ST_FREE = 3'h7
	} mdio_st_t;
endpackage : mdio_pkg

/* File: verilog/mdio_sync.sv */
// Three-stage input synchroniser that passes a change once stages agree
module mdio_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] out;
	} mdio_sync_t;
	mdio_sync_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		s_d.s1 = din;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		// Only agreeing later stages pass; the first stage feeds nothing else
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.out[i] = s_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign dout = s_q.out;
endmodule : mdio_sync

/* File: testbench/mdio_host.sv */
// Host controller model driving the remote and direct input levels
module mdio_host (
	input wire logic clk,
	output logic [15:0] rin,
	output logic [5:0] din
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		rin = '0;
		din = '0;
	end
	// Remote slots change only as link-decoded levels
	task automatic r(int i, logic v, int lag = 0);
		repeat (lag + 1) @(posedge clk);
		#2 rin[i] = v;  // Held until the next call
	endtask : r
	task automatic d(int i, logic v);
		@(posedge clk);
		#2 din[i] = v;
	endtask : d
endmodule : mdio_host

/* File: testbench/mdio_ctrl_tb_top.sv */
// Self-checking bench for the motor drive I/O control
module mdio_ctrl_tb_top
	import mdio_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [20:0] FB = (21'h1 << F_EXC_CMD) | (21'h1 << F_PANEL);
	logic clk = 0;
	logic reset = 1;
	logic pulse_mode = 0;
	logic motor_stopped = 0;
	logic clockwise_pulse = 0;
	logic counterclockwise_pulse = 0;
	logic map_wr = 0;
	logic [1:0] map_tbl = 0;
	logic [3:0] map_idx = 0;
	logic [FW-1:0] map_val = 0;
	logic [NO-1:0] status = 0;
	logic [ND-1:0] din;
	logic [NR-1:0] rin;
	logic [NF-1:0] func;
	logic [NR-1:0] rout;
	logic excite, dyn_brake, brake_release, ready, pulse_accept_ready;
	logic clear_dev, halt_now, halt_decel, discard_travel, in_position;
	logic [1:0] stop_action_setting;
	logic cw_step, ccw_step;
	logic ex_q = 0;
	logic [15:0] lfsr = 16'h8CCD;
	logic [15:0] ro_e;
	logic [65:0] en;
	logic [65:0] q[$];
	int fail_count = 0;
	int n_checks = 0;
	event sample;
	logic [4:0] isl [16] = '{F_OP_SEL0, F_OP_SEL1, F_OP_SEL2, F_START,
		F_HOME, F_STOP, F_RELEASE, F_ALARM_CLR, F_DSEL0, F_DSEL1, F_DSEL2,
		F_SEQ_START, F_FW_JOG, F_RV_JOG, F_FORWARD_POSITION_MOVE_INPUT, F_REVERSE_POSITION_MOVE_INPUT};
	logic [4:0] rsl [16] = '{O_ECHO0, O_ECHO1, O_ECHO2, O_START_ECHO,
		O_HOME_END, O_READY, O_INFORMATION_FLAG_OUTPUT, O_ALARM, O_BUSY, O_ZONE0, O_ZONE1,
		O_ZONE2, O_TIMING, O_MOVE, O_INPOS, O_TORQUE};

	always #25 clk = ~clk;

	mdio_host host (.clk, .rin, .din);
	mdio_ctrl dut (.clk, .reset, .din, .rin, .clockwise_pulse,
		.counterclockwise_pulse, .pulse_mode, .motor_stopped, .status,
		.map_wr, .map_tbl, .map_idx, .map_val, .func, .rout,
		.cw_step, .ccw_step, .excite, .dyn_brake, .brake_release,
		.ready, .pulse_accept_ready, .clear_dev, .halt_now, .halt_decel,
		.discard_travel, .in_position, .stop_action_setting);

	function automatic logic [15:0] nx(logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : nx
	function automatic logic [31:0] obs(logic [1:0] k);
		case (k)
			2'h0: return {20'h0, ccw_step, cw_step, in_position,
				halt_decel, discard_travel,
				halt_now, clear_dev, pulse_accept_ready, ready,
				brake_release, dyn_brake, excite};
			2'h1: return {11'h0, func};
			2'h2: return {16'h0, rout};
			default: return {30'h0, stop_action_setting};
		endcase
	endfunction : obs
	task automatic chk(logic [31:0] s, logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk
	task automatic ex(logic [1:0] k, logic [31:0] m, logic [31:0] v);
		q.push_back({k, m, v & m});
		->sample;
	endtask : ex
	task automatic go(int n = 8);
		repeat (n) @(posedge clk);
		#2;
	endtask : go
	task automatic mw(logic [1:0] t, logic [3:0] i, logic [4:0] v);
		@(posedge clk);
		#2 {map_wr, map_tbl, map_idx, map_val} = {1'b1, t, i, v};
		@(posedge clk);
		#2 map_wr = 0;
	endtask : mw
	task automatic done(string s);
		$display("Test %s finished", s);
	endtask : done
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test

	// Oldest note is compared with the outputs once they have settled
	always begin
		@(sample);
		while (q.size() > 0) begin
			en = q.pop_front();
			chk(obs(en[65:64]) & en[63:32], en[31:0]);
		end
	end

	// Brake must still hold on the edge where excitation first appears
	always @(posedge clk) begin
		if (!reset && excite === 1'b1 && ex_q === 1'b0)
			chk({31'h0, brake_release}, 32'h0);
		ex_q <= excite;
	end

	initial begin
		#(50 * 6000);
		fail_count++;
		stop_test();
	end

	initial begin
		repeat (2) @(posedge clk);
		#2 reset = 0;
		go();
		ex(3, 3, 3);
		ex(1, 32'h1FFFFF, FB);
		ex(0, 32'h1FD, 32'h1D);
		done("reset");
		for (int i = 0; i < 16; i++) begin
			lfsr = nx(lfsr);
			host.r(i, 1, lfsr[1:0]);
			go();
			ex(1, 32'h1FFFFF, FB | (21'h1 << isl[i]));
			host.r(i, 0);
		end
		go();
		done("remote inputs");
		repeat (4) begin
			lfsr = nx(lfsr);
			@(posedge clk);
			#2 status = {lfsr[1:0], lfsr};
			go(3);
			for (int i = 0; i < 16; i++)
				ro_e[i] = status[rsl[i]];
			ro_e[5] = 1'b1;
			ex(2, 32'hBFF0, {16'h0, ro_e});
		end
		done("remote outputs");
		mw(T_RIN, 8, F_START);
		mw(T_DIN, 5, F_START);
		host.r(8, 1);
		go();
		ex(1, 32'h1FFFFF, FB | (21'h1 << F_START));
		ex(2, 32'hF, 32'h8);
		host.r(8, 0);
		host.d(5, 1);
		go();
		ex(1, 32'h1FFFFF, FB | (21'h1 << F_START));
		host.d(5, 0);
		done("merge");
		mw(T_RIN, 15, F_EXC_CMD);
		go();
		ex(0, 32'h1F, 32'h02);
		host.r(15, 1);
		go();
		ex(0, 32'h1F, 32'h1D);
		mw(T_DIN, 4, F_EXC_CMD);
		go();
		ex(0, 32'h1F, 32'h02);
		host.r(6, 1);
		go();
		ex(0, 32'h05, 32'h04);
		host.r(6, 0);
		go();
		ex(0, 32'h05, 32'h00);
		host.d(4, 1);
		go();
		ex(0, 32'h1F, 32'h1D);
		host.r(6, 1);
		go();
		ex(0, 32'h1D, 32'h04);
		host.r(6, 0);
		go();
		ex(0, 32'h1D, 32'h1D);
		done("excitation");
		mw(T_RIN, 9, F_DEV_CLR);
		@(posedge clk);
		#2 pulse_mode = 1;
		host.r(9, 1);
		go();
		ex(0, 32'h1FD, 32'h65);
		@(posedge clk);
		#2 pulse_mode = 0;
		go(3);
		ex(0, 32'h1FD, 32'hE5);
		host.r(9, 0);
		go();
		ex(0, 32'h1FD, 32'h1D);
		done("clear");
		mw(T_RIN, 10, F_STOP_OFF);
		@(posedge clk);
		#2 pulse_mode = 1;
		host.r(10, 1);
		go();
		ex(0, 32'h1FD, 32'h40);
		host.r(10, 0);
		go();
		ex(0, 32'h1FD, 32'h1D);
		@(posedge clk);
		#2 pulse_mode = 0;
		for (int s = 0; s < 4; s++) begin
			mw(T_STOP_ACT, 0, 5'(s));
			#0 motor_stopped = 0;
			go(2);
			ex(3, 3, s);
			host.r(10, 1);
			go();
			if (s < 2) begin
				ex(0, 32'h1FD, 32'hC0);
			end else begin
				ex(0, 32'h1FD, 32'h105);
				@(posedge clk);
				#2 motor_stopped = 1;
				go(3);
				ex(0, 32'hBD, 32'h80);
			end
			host.r(10, 0);
			go();
			ex(0, 32'h1FD, 32'h1D);
		end
		done("deenergizing stop");
		{clockwise_pulse, counterclockwise_pulse} = 2'h2;
		go();
		ex(0, 32'hC00, 32'h400);
		host.r(9, 1);
		go();
		ex(0, 32'hC00, 32'h0);
		host.r(9, 0);
		{clockwise_pulse, counterclockwise_pulse} = 2'h1;
		go();
		ex(0, 32'hC00, 32'h800);
		{clockwise_pulse, counterclockwise_pulse} = 2'h0;
		done("pulses");
		@(posedge clk);
		#2 status[O_INPOS] = 1;
		host.r(3, 1);
		host.r(3, 0, 4);
		go();
		ex(0, 32'h210, 32'h210);
		ex(2, 32'h4000, 32'h4000);
		host.r(5, 1);
		go();
		ex(0, 32'h210, 32'h0);
		host.r(5, 0);
		go();
		ex(0, 32'h210, 32'h10);
		done("in position");
		go();
		stop_test();
	end
endmodule : mdio_ctrl_tb_top
